// ==== src/ets_pkg.sv ====
// Shared constants for the encoder terminal parameter register set
package ets_pkg;

   // Register numbers carried in the low six bits of the control byte
   localparam logic [5:0] ETS_ADDR_DIAG    = 6'h06;
   localparam logic [5:0] ETS_ADDR_CMD     = 6'h07;
   localparam logic [5:0] ETS_ADDR_TYPE    = 6'h08;
   localparam logic [5:0] ETS_ADDR_FWREV   = 6'h09;
   localparam logic [5:0] ETS_ADDR_CHAIN   = 6'h0a;
   localparam logic [5:0] ETS_ADDR_CHANS   = 6'h0b;
   localparam logic [5:0] ETS_ADDR_MINLEN  = 6'h0c;
   localparam logic [5:0] ETS_ADDR_LAYOUT  = 6'h0d;
   localparam logic [5:0] ETS_ADDR_ALIGN   = 6'h0f;
   localparam logic [5:0] ETS_ADDR_MAKER_LO = 6'h10;
   localparam logic [5:0] ETS_ADDR_MAKER_HI = 6'h1e;
   localparam logic [5:0] ETS_ADDR_UNLOCK  = 6'h1f;
   localparam logic [5:0] ETS_ADDR_MODE    = 6'h20;

   // Nonvolatile slots: maker words first, mode word last
   localparam int unsigned ETS_NV_WORDS    = 16;
   localparam logic [3:0]  ETS_NV_MODE_IDX = 4'hf;

   // Unlock key and reset values
   localparam logic [15:0] ETS_UNLOCK_VALUE = 16'h1235;
   localparam logic [15:0] ETS_MODE_DEFAULT = 16'h2200;
   localparam logic [15:0] ETS_ZERO16       = 16'h0000;
   localparam logic [15:0] ETS_CHAIN_VALUE  = 16'h0218;
   localparam logic [15:0] ETS_CHANS_VALUE  = 16'h0130;
   localparam logic [15:0] ETS_MINLEN_VALUE = 16'h3030;
   localparam logic [15:0] ETS_LAYOUT_VALUE = 16'h0000;

   // Control byte fields
   localparam int unsigned ETS_CB_REG   = 7;
   localparam int unsigned ETS_CB_WRITE = 6;

   // Operating mode word fields
   localparam int unsigned ETS_MB_GATE_POL  = 1;
   localparam int unsigned ETS_MB_STMAP_LO  = 2;
   localparam int unsigned ETS_MB_LATCH_LO  = 4;
   localparam int unsigned ETS_MB_EVAL_LO   = 10;
   localparam int unsigned ETS_MB_UPDOWN    = 15;
   localparam int unsigned ETS_ST_BIT5      = 5;
   localparam int unsigned ETS_ST_BIT6      = 6;

   // Field codes
   localparam logic [1:0] ETS_STMAP_BOTH = 2'h2;
   localparam logic [1:0] ETS_STMAP_INV  = 2'h3;
   localparam logic [2:0] ETS_LATCH_EXT  = 3'h0;
   localparam logic [2:0] ETS_LATCH_PER  = 3'h1;
   localparam logic [1:0] ETS_EVAL_ONE   = 2'h1;
   localparam logic [1:0] ETS_EVAL_TWO   = 2'h2;

   // Normalised counting factor handed to the counter
   typedef enum logic [1:0] {
      ETS_CNT_X4 = 2'h0,
      ETS_CNT_X1 = 2'h1,
      ETS_CNT_X2 = 2'h2
   } ets_factor_t;

   // Register access sequencer, one-hot
   typedef enum logic [1:0] {
      ETS_ST_IDLE = 2'b01,
      ETS_ST_EXEC = 2'b10
   } ets_state_t;

endpackage

// ==== src/ets_nv_store.sv ====
// Parameter store for the maker and operating mode words
`timescale 1ns/1ps
`default_nettype none
module ets_nv_store
   import ets_pkg::*;
#(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = ETS_NV_WORDS
) (
   input  wire logic                     clock,
   input  wire logic                     rst,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
   input  wire logic [WIDTH-1:0]         wr_data,
   input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output logic      [WIDTH-1:0]         rd_data,
   output logic      [WIDTH-1:0]         mode_word
);

   generate
      if (WIDTH != 16 || DEPTH != ETS_NV_WORDS) begin : g_bad
         $error("ets_nv_store: only 16 words of 16 bits are supported");
      end
   endgenerate

   logic [WIDTH-1:0] mem_r   [DEPTH];
   logic [WIDTH-1:0] mem_nxt [DEPTH];

   // One word per slot; mode slot restores its working default
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_word
         always_comb begin
            mem_nxt[gi] = mem_r[gi];
            if (wr_en && wr_idx == ($clog2(DEPTH))'(gi)) begin
               mem_nxt[gi] = wr_data;
            end
         end
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               mem_r[gi] <= (gi == ETS_NV_MODE_IDX) ? ETS_MODE_DEFAULT : ETS_ZERO16;
            end else begin
               mem_r[gi] <= mem_nxt[gi];
            end
         end
      end
   endgenerate

   // Read by index; flip-flop storage stands in for the serial part
   assign rd_data   = mem_r[rd_idx];
   assign mode_word = mem_r[ETS_NV_MODE_IDX];

endmodule
`default_nettype wire

// ==== src/ets_param_regs.sv ====
// Parameter register bank of the incremental encoder terminal
//
// Notes on behaviour
// - Writing the unlock key lifts write protection of the stored parameter areas.
// - Any other key value written sets or keeps write protection active.
// - Unprotected, the key register reads back the unlock value.
// - Protected, the key register reads as zero.
// - Maker parameter writes are dropped unless the unlock value is held.
// - Maker and mode words sit in retained storage; the key is volatile. Here rst also clears the maker words and resets the mode word to 0x2200.
// - Identification registers 8 to 13 are constants; writes leave them unchanged.
// - Command register takes function and parameter, returns function with a zero upper byte.
// - Firmware revision register presents the revision as ASCII characters.
// - Chain layout register gives shift register count and bit length.
// - Minimum length register MSB marks the control/status byte optional.
// - Payload layout register holds a data type code from the table.
// - Alignment register is plain writable volatile storage.
// - Diagnostic register reports extra diagnostics such as parity errors.
// - Mode select register defaults to 0x2200 after initialisation.
// - Mode bit 1 picks which gate level inhibits counting.
// - Mode bits 2-3 map the active-low status input onto status bits 5, 6.
// - Mode bits 4-6 choose external latch or period measurement.
// - Mode bits 10-11 choose four-, one- or two-fold evaluation.
// - Mode bit 15 switches encoder mode to up/down counter mode.
// - Control bit 7 turns the first two data bytes into register traffic.
// - In register access, control bit 6 clear reads, set writes.
`timescale 1ns/1ps
`default_nettype none
module ets_param_regs
   import ets_pkg::*;
#(
   parameter logic [15:0] TYPE_ID  = 16'h0a5c, // arbitrary value
   parameter logic [15:0] FW_REV   = 16'h3141, // arbitrary value
   parameter int unsigned NV_DEPTH = ETS_NV_WORDS
) (
   input  wire logic        clock,
   input  wire logic        rst,
   // Cyclic frame from the coupler
   input  wire logic        frame_valid,
   input  wire logic [7:0]  ctrl_byte,
   input  wire logic [15:0] out_data,
   // Counter datapath status and pins
   input  wire logic [7:0]  proc_status,
   input  wire logic        status_input_n,
   input  wire logic        gate_in,
   input  wire logic        parity_err,
   // Frame answer to the coupler
   output logic [7:0]       status_byte,
   output logic [15:0]      in_data,
   output logic             reg_reply,
   // Mode controls for the counter datapath, and the write protection state
   output logic             count_inhibit,
   output ets_factor_t      count_factor,
   output logic             ext_latch_en,
   output logic             period_meas_en,
   output logic             updown_mode,
   output logic             write_unlocked
);

   // Depth is fixed by the slot map
   generate
      if (NV_DEPTH != ETS_NV_WORDS) begin : g_bad_depth
         $error("ets_param_regs: NV_DEPTH must equal the stored word count");
      end
   endgenerate

   // Maker area window, used by read and write decode alike
   function automatic logic in_maker(input logic [5:0] a);
      in_maker = (a >= ETS_ADDR_MAKER_LO) && (a <= ETS_ADDR_MAKER_HI);
   endfunction

   // Stored slot index of a maker or mode register
   // Result only used for maker and mode numbers
   function automatic logic [3:0] nv_index(input logic [5:0] a);
      if (a == ETS_ADDR_MODE) begin
         nv_index = ETS_NV_MODE_IDX;
      end else begin
         nv_index = 4'(a - ETS_ADDR_MAKER_LO);
      end
   endfunction

   // Sequencer and volatile registers; one request in flight,
   // so a frame during execution is dropped, not queued,
   // which keeps the answer latency fixed
   ets_state_t  state_r, state_nxt;
   logic [5:0]  addr_r, addr_nxt;
   logic        wr_r, wr_nxt;
   logic [15:0] wdata_r, wdata_nxt;
   logic [15:0] key_r, key_nxt;
   logic [15:0] align_r, align_nxt;
   logic [7:0]  func_r, func_nxt;
   logic [7:0]  fparam_r, fparam_nxt;
   logic [15:0] diag_r, diag_nxt;
   logic        unlocked;
   logic        diag_read;

   // Stored words
   logic        nv_wr_en;
   logic [3:0]  nv_idx;
   logic [15:0] nv_rd_data;
   logic [15:0] mode_word;

   ets_nv_store #(
      .WIDTH (16),
      .DEPTH (NV_DEPTH)
   ) u_store (
      .clock     (clock),
      .rst       (rst),
      .wr_en     (nv_wr_en),
      .wr_idx    (nv_idx),
      .wr_data   (wdata_r),
      .rd_idx    (nv_idx),
      .rd_data   (nv_rd_data),
      .mode_word (mode_word)
   );

   // Protection is lifted only by the exact key
   assign unlocked = (key_r == ETS_UNLOCK_VALUE);

   // Stored writes need the key for both maker and mode words
   assign nv_idx   = nv_index(addr_r);
   assign nv_wr_en = (state_r == ETS_ST_EXEC) && wr_r && unlocked
                     && (in_maker(addr_r) || addr_r == ETS_ADDR_MODE);
   // A diagnostic read clears the flags
   assign diag_read = (state_r == ETS_ST_EXEC) && !wr_r && addr_r == ETS_ADDR_DIAG;

   // Take a register request, execute it on the next cycle
   always_comb begin
      state_nxt  = state_r;
      addr_nxt   = addr_r;
      wr_nxt     = wr_r;
      wdata_nxt  = wdata_r;
      key_nxt    = key_r;
      align_nxt  = align_r;
      func_nxt   = func_r;
      fparam_nxt = fparam_r;
      case (state_r)
         ETS_ST_IDLE: begin
            // Only register frames start
            if (frame_valid && ctrl_byte[ETS_CB_REG]) begin
               addr_nxt  = ctrl_byte[5:0];
               wr_nxt    = ctrl_byte[ETS_CB_WRITE];
               wdata_nxt = out_data;
               state_nxt = ETS_ST_EXEC;
            end
         end
         ETS_ST_EXEC: begin
            state_nxt = ETS_ST_IDLE;
            // Reads are served by the answer mux
            if (wr_r) begin
               // Volatile targets; constants and reserved slots drop writes
               if (addr_r == ETS_ADDR_UNLOCK) begin
                  key_nxt = wdata_r;
               end else if (addr_r == ETS_ADDR_ALIGN) begin
                  align_nxt = wdata_r;
               end else if (addr_r == ETS_ADDR_CMD) begin
                  func_nxt   = wdata_r[7:0];
                  fparam_nxt = wdata_r[15:8];
               end
            end
         end
         default: begin
            // Stray codes return to idle
            state_nxt = ETS_ST_IDLE;
         end
      endcase
   end

   // Diagnostic flags: new error wins over the read-clear
   always_comb begin
      diag_nxt = diag_r;
      if (diag_read) begin
         diag_nxt = ETS_ZERO16;
      end
      if (parity_err) begin
         diag_nxt[0] = 1'b1;
      end
   end

   // Sequencer register flops
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r  <= ETS_ST_IDLE;
         addr_r   <= 6'h00;
         wr_r     <= 1'b0;
         wdata_r  <= ETS_ZERO16;
         key_r    <= ETS_ZERO16;
         align_r  <= ETS_ZERO16;
         func_r   <= 8'h00;
         fparam_r <= 8'h00;
         diag_r   <= ETS_ZERO16;
      end else begin
         state_r  <= state_nxt;
         addr_r   <= addr_nxt;
         wr_r     <= wr_nxt;
         wdata_r  <= wdata_nxt;
         key_r    <= key_nxt;
         align_r  <= align_nxt;
         func_r   <= func_nxt;
         fparam_r <= fparam_nxt;
         diag_r   <= diag_nxt;
      end
   end

   // Read decode from the latched register number
   // Type and firmware revision words are parameters: new defaults,
   // not new logic, for another terminal type
   logic [15:0] rd_word;

   // Reserved and unmapped numbers fall through to zero
   // Each number decodes once
   always_comb begin
      rd_word = ETS_ZERO16;
      if (addr_r == ETS_ADDR_DIAG) begin
         rd_word = diag_r;
      end else if (addr_r == ETS_ADDR_CMD) begin
         rd_word = {8'h00, func_r};
      end else if (addr_r == ETS_ADDR_TYPE) begin
         rd_word = TYPE_ID;
      end else if (addr_r == ETS_ADDR_FWREV) begin
         rd_word = FW_REV;
      end else if (addr_r == ETS_ADDR_CHAIN) begin
         rd_word = ETS_CHAIN_VALUE;
      end else if (addr_r == ETS_ADDR_CHANS) begin
         rd_word = ETS_CHANS_VALUE;
      end else if (addr_r == ETS_ADDR_MINLEN) begin
         rd_word = ETS_MINLEN_VALUE;
      end else if (addr_r == ETS_ADDR_LAYOUT) begin
         rd_word = ETS_LAYOUT_VALUE;
      end else if (addr_r == ETS_ADDR_ALIGN) begin
         rd_word = align_r;
      end else if (in_maker(addr_r) || addr_r == ETS_ADDR_MODE) begin
         rd_word = nv_rd_data;
      end else if (addr_r == ETS_ADDR_UNLOCK) begin
         rd_word = unlocked ? key_r : ETS_ZERO16;
      end
   end

   // Frame answer; register and process answers share
   // the status byte, and the register answer wins the
   // execute cycle
   logic [7:0]  status_r, status_nxt;
   logic [15:0] indata_r, indata_nxt;
   logic        reply_r, reply_nxt;
   logic        st_active;
   logic [1:0]  st_map;

   // Active-low pin; map code picks bit 6
   assign st_active = !status_input_n;
   assign st_map    = mode_word[ETS_MB_STMAP_LO +: 2];

   // Register answers leave one cycle after execution; process frames
   // are answered one cycle after the frame since the counter owns that data
   always_comb begin
      status_nxt = status_r;
      indata_nxt = indata_r;
      reply_nxt  = 1'b0;
      if (state_r == ETS_ST_EXEC) begin
         status_nxt = {1'b1, wr_r, addr_r};
         indata_nxt = wr_r ? wdata_r : rd_word;
         reply_nxt  = 1'b1;
      end else if (frame_valid && !ctrl_byte[ETS_CB_REG]) begin
         status_nxt = proc_status;
         status_nxt[ETS_CB_REG] = 1'b0;
         status_nxt[ETS_ST_BIT5] = st_active;
         if (st_map == ETS_STMAP_BOTH) begin
            status_nxt[ETS_ST_BIT6] = st_active;
         end else if (st_map == ETS_STMAP_INV) begin
            status_nxt[ETS_ST_BIT6] = !st_active;
         end
      end
   end

   // A command read returns zero in the upper half and the function in the lower half
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         status_r <= 8'h00;
         indata_r <= ETS_ZERO16;
         reply_r  <= 1'b0;
      end else begin
         status_r <= status_nxt;
         indata_r <= indata_nxt;
         reply_r  <= reply_nxt;
      end
   end

   // Mode decode for the counter datapath; outputs lag
   // the mode word and the gate pin by one cycle, which
   // the counter has to tolerate
   logic        inhibit_nxt, inhibit_r;
   ets_factor_t factor_nxt, factor_r;
   logic        extl_nxt, extl_r;
   logic        per_nxt, per_r;
   logic        updn_nxt, updn_r;
   logic        unl_r;

   // Reserved latch codes enable neither function
   always_comb begin
      // Bit clear: high gate inhibits; set: low gate inhibits
      inhibit_nxt = mode_word[ETS_MB_GATE_POL] ? !gate_in : gate_in;
      extl_nxt = mode_word[ETS_MB_LATCH_LO +: 3] == ETS_LATCH_EXT;
      per_nxt  = mode_word[ETS_MB_LATCH_LO +: 3] == ETS_LATCH_PER;
      updn_nxt = mode_word[ETS_MB_UPDOWN];
      // Codes 00 and 11 both mean x4
      case (mode_word[ETS_MB_EVAL_LO +: 2])
         ETS_EVAL_ONE: factor_nxt = ETS_CNT_X1;
         ETS_EVAL_TWO: factor_nxt = ETS_CNT_X2;
         default:      factor_nxt = ETS_CNT_X4;
      endcase
   end

   // Registered so every output leaves a flip-flop
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         inhibit_r <= 1'b0;
         factor_r  <= ETS_CNT_X4;
         extl_r    <= 1'b1;
         per_r     <= 1'b0;
         updn_r    <= 1'b0;
         unl_r     <= 1'b0;
      end else begin
         inhibit_r <= inhibit_nxt;
         factor_r  <= factor_nxt;
         extl_r    <= extl_nxt;
         per_r     <= per_nxt;
         updn_r    <= updn_nxt;
         unl_r     <= unlocked;
      end
   end

   // Ports straight from the flops
   assign status_byte    = status_r;
   assign in_data        = indata_r;
   assign reg_reply      = reply_r;
   assign count_inhibit  = inhibit_r;
   assign count_factor   = factor_r;
   assign ext_latch_en   = extl_r;
   assign period_meas_en = per_r;
   assign updown_mode    = updn_r;
   assign write_unlocked = unl_r;

endmodule
`default_nettype wire

// ==== test/ets_param_regs_asserts.sv ====
// Port-level checks for the parameter register bank
`timescale 1ns/1ps
`default_nettype none
module ets_param_regs_asserts
   import ets_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        frame_valid,
   input  wire logic [7:0]  ctrl_byte,
   input  wire logic [15:0] out_data,
   input  wire logic        status_input_n,
   input  wire logic [7:0]  status_byte,
   input  wire logic [15:0] in_data,
   input  wire logic        reg_reply,
   input  wire logic        write_unlocked
);
   logic       busy_r;
   logic       taken;
   logic       wr;
   logic [5:0] addr;

   // A frame in the busy cycle is dropped, so it must not count as a request
   assign taken = frame_valid && ctrl_byte[ETS_CB_REG] && !busy_r;
   assign wr    = ctrl_byte[ETS_CB_WRITE];
   assign addr  = ctrl_byte[5:0];

   // Busy for the one cycle after an accepted request
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= taken;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_reply_timing;
      taken |-> ##1 !reg_reply ##1 reg_reply;
   endproperty
   a_reply_timing: assert property (p_reply_timing)
      else $error("register answer not two cycles after request");
   property p_reply_cause;
      reg_reply |-> $past(taken, 2) ##1 !reg_reply;
   endproperty
   a_reply_cause: assert property (p_reply_cause)
      else $error("register answer without request or longer than one cycle");
   property p_status_echo;
      taken |-> ##2 status_byte == $past(ctrl_byte, 2);
   endproperty
   a_status_echo: assert property (p_status_echo)
      else $error("register answer status byte wrong");
   property p_write_echo;
      taken && wr |-> ##2 in_data == $past(out_data, 2);
   endproperty
   a_write_echo: assert property (p_write_echo)
      else $error("write data not echoed");
   property p_unlock;
      taken && wr && addr == ETS_ADDR_UNLOCK && out_data == ETS_UNLOCK_VALUE |-> ##3 write_unlocked;
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("unlock key did not lift protection");
   property p_lock;
      taken && wr && addr == ETS_ADDR_UNLOCK && out_data != ETS_UNLOCK_VALUE |-> ##3 !write_unlocked;
   endproperty
   a_lock: assert property (p_lock)
      else $error("wrong key left protection off");
   property p_key_read;
      taken && !wr && addr == ETS_ADDR_UNLOCK
         |-> ##2 in_data == (write_unlocked ? ETS_UNLOCK_VALUE : ETS_ZERO16);
   endproperty
   a_key_read: assert property (p_key_read)
      else $error("key register read value wrong");
   property p_rsvd_read;
      taken && !wr && (addr < ETS_ADDR_DIAG || addr == 6'h0e) |-> ##2 in_data == ETS_ZERO16;
   endproperty
   a_rsvd_read: assert property (p_rsvd_read)
      else $error("reserved register not zero");
   property p_chain_read;
      taken && !wr && addr == ETS_ADDR_CHAIN |-> ##2 in_data == ETS_CHAIN_VALUE;
   endproperty
   a_chain_read: assert property (p_chain_read)
      else $error("chain layout value wrong");
   property p_status_map;
      frame_valid && !ctrl_byte[ETS_CB_REG] && !busy_r
         |=> status_byte[ETS_ST_BIT5] == !$past(status_input_n) && !status_byte[7];
   endproperty
   a_status_map: assert property (p_status_map)
      else $error("status input not mapped to status bit 5");
endmodule
`default_nettype wire

// ==== test/ets_coupler_model.sv ====
// Behavioural coupler issuing register and process frames
`timescale 1ns/1ps
`default_nettype none
module ets_coupler_model
   import ets_pkg::*;
(
   input  wire logic        clock,
   output logic             frame_valid,
   output logic [7:0]       ctrl_byte,
   output logic [15:0]      out_data,
   input  wire logic [15:0] in_data,
   input  wire logic        reg_reply
);
   // Lines idle until the first frame
   initial begin
      frame_valid = 1'b0;
      ctrl_byte   = 8'h00;
      out_data    = 16'h0000;
   end

   // One register transfer; lines show the inverse once the frame is over
   task automatic reg_xfer(input logic wr, input logic [5:0] addr, input logic [15:0] wdata,
                           output logic [15:0] rdata, output logic ok);
      @(negedge clock);
      frame_valid <= 1'b1;
      ctrl_byte   <= {1'b1, wr, addr};
      // Reserved mode bits always sent as zero
      out_data    <= (addr == ETS_ADDR_MODE) ? (wdata & 16'h8c7e) : wdata;
      @(negedge clock);
      frame_valid <= 1'b0;
      ctrl_byte   <= ~{1'b1, wr, addr};
      out_data    <= ~wdata;
      ok = 1'b0;
      rdata = 16'h0000;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(negedge clock);
         if (reg_reply === 1'b1) begin
            ok = 1'b1;
            rdata = in_data;
         end
      end
   endtask

   // Process frame; status byte settles one edge after it is taken
   task automatic proc_frame();
      @(negedge clock);
      frame_valid <= 1'b1;
      ctrl_byte   <= 8'h00;
      @(negedge clock);
      frame_valid <= 1'b0;
      @(negedge clock);
   endtask
endmodule
`default_nettype wire

// ==== test/ets_param_regs_tb.sv ====
// Self-checking bench for the parameter register bank
`timescale 1ns/1ps
`default_nettype none
module ets_param_regs_tb
   import ets_pkg::*;
   ;
   localparam logic [15:0] TB_TYPE_ID = 16'h0b7e; // arbitrary value
   localparam logic [15:0] TB_FW_REV  = 16'h322e; // arbitrary value
   localparam int          TIMEOUT    = 5000;
   logic        clock, rst, frame_valid, reg_reply, ok;
   logic        status_input_n, gate_in, parity_err, count_inhibit;
   logic        ext_latch_en, period_meas_en, updown_mode, write_unlocked;
   logic [7:0]  ctrl_byte, proc_status, status_byte;
   logic [15:0] out_data, in_data, rd;
   ets_factor_t count_factor;
   int          num_errors, n_checks, cycles;

   ets_param_regs #(.TYPE_ID(TB_TYPE_ID), .FW_REV(TB_FW_REV)) ets_param_regs_inst (
      .clock(clock), .rst(rst), .frame_valid(frame_valid), .ctrl_byte(ctrl_byte),
      .out_data(out_data), .proc_status(proc_status), .status_input_n(status_input_n),
      .gate_in(gate_in), .parity_err(parity_err), .status_byte(status_byte),
      .in_data(in_data), .reg_reply(reg_reply), .count_inhibit(count_inhibit),
      .count_factor(count_factor), .ext_latch_en(ext_latch_en),
      .period_meas_en(period_meas_en), .updown_mode(updown_mode),
      .write_unlocked(write_unlocked));
   ets_coupler_model ets_coupler_model_inst (
      .clock(clock), .frame_valid(frame_valid), .ctrl_byte(ctrl_byte),
      .out_data(out_data), .in_data(in_data), .reg_reply(reg_reply));

   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask

   // Register transfer that must always be answered
   task automatic acc(input logic wr, input logic [5:0] addr, input logic [15:0] wdata);
      ets_coupler_model_inst.reg_xfer(wr, addr, wdata, rd, ok);
      chk("reply", 16'h0001, {15'h0, ok});
   endtask

   task automatic rdchk(input logic [5:0] addr, input logic [15:0] exp);
      acc(1'b0, addr, 16'h0000);
      chk("read", exp, rd);
   endtask

   // Packs the mode outputs: inhibit, updown, period, latch, factor
   task automatic chk_mode(input logic [15:0] exp);
      chk("mode outputs", exp, {10'h0, count_inhibit, updown_mode, period_meas_en,
                                ext_latch_en, count_factor});
   endtask

   task automatic t_defaults();
      rdchk(ETS_ADDR_MODE, ETS_MODE_DEFAULT);
      chk_mode(16'h0024);
      rdchk(ETS_ADDR_UNLOCK, ETS_ZERO16);
   endtask

   // Constants other than the firmware revision must survive a write of all ones
   task automatic t_idregs();
      logic [5:0]  ta [8] = '{ETS_ADDR_TYPE, ETS_ADDR_CHAIN, ETS_ADDR_CHANS, ETS_ADDR_MINLEN,
                              ETS_ADDR_LAYOUT, 6'h0e, 6'h00, 6'h05};
      logic [15:0] te [8] = '{TB_TYPE_ID, 16'h0218, 16'h0130, 16'h3030, 16'h0000, 16'h0000,
                              16'h0000, 16'h0000};
      for (int i = 0; i < 8; i++) begin
         acc(1'b1, ta[i], 16'hffff);
         rdchk(ta[i], te[i]);
      end
      rdchk(ETS_ADDR_FWREV, TB_FW_REV);
      chk("ascii", 16'h0001, {15'h0, rd[15:8] inside {[8'h20:8'h7e]} &&
                                     rd[7:0] inside {[8'h20:8'h7e]}});
   endtask

   task automatic t_protect();
      acc(1'b1, ETS_ADDR_MAKER_LO, 16'hbeef);
      rdchk(ETS_ADDR_MAKER_LO, 16'h0000);
      acc(1'b1, ETS_ADDR_MODE, 16'h8000);
      rdchk(ETS_ADDR_MODE, ETS_MODE_DEFAULT);
      acc(1'b1, ETS_ADDR_UNLOCK, ETS_UNLOCK_VALUE);
      @(negedge clock);
      chk("unlocked", 16'h0001, {15'h0, write_unlocked});
      rdchk(ETS_ADDR_UNLOCK, ETS_UNLOCK_VALUE);
      acc(1'b1, ETS_ADDR_MAKER_LO, 16'hbeef);
      acc(1'b1, ETS_ADDR_MAKER_HI, 16'h1e1e);
      rdchk(ETS_ADDR_MAKER_LO, 16'hbeef);
      rdchk(ETS_ADDR_MAKER_HI, 16'h1e1e);
      acc(1'b1, ETS_ADDR_ALIGN, 16'h00a5);
      rdchk(ETS_ADDR_ALIGN, 16'h00a5);
      acc(1'b1, ETS_ADDR_CMD, 16'hab05);
      rdchk(ETS_ADDR_CMD, 16'h0005);
   endtask

   // Mode words with gate held high, then the status input maps
   task automatic t_modes();
      logic [15:0] mw [6] = '{16'h0400, 16'h0800, 16'h0c00, 16'h0010, 16'h8000, 16'h0002};
      logic [15:0] me [6] = '{16'h0025, 16'h0026, 16'h0024, 16'h0028, 16'h0034, 16'h0004};
      logic [15:0] sw [3] = '{16'h0000, 16'h0008, 16'h000c};
      logic [7:0]  se [6] = '{8'h40, 8'h00, 8'h40, 8'h60, 8'h60, 8'h20};
      for (int i = 0; i < 6; i++) begin
         acc(1'b1, ETS_ADDR_MODE, mw[i]);
         @(negedge clock);
         chk_mode(me[i]);
      end
      // Status input idle for three maps, then asserted
      for (int i = 0; i < 6; i++) begin
         status_input_n <= (i < 3);
         acc(1'b1, ETS_ADDR_MODE, sw[i % 3]);
         ets_coupler_model_inst.proc_frame();
         chk("status map", {8'h0, se[i]}, {8'h0, status_byte & 8'he0});
      end
   endtask

   task automatic t_lock();
      acc(1'b1, ETS_ADDR_UNLOCK, 16'h1234);
      @(negedge clock);
      chk("unlocked", 16'h0000, {15'h0, write_unlocked});
      rdchk(ETS_ADDR_UNLOCK, ETS_ZERO16);
      acc(1'b1, ETS_ADDR_MAKER_LO, 16'h0f0f);
      rdchk(ETS_ADDR_MAKER_LO, 16'hbeef);
   endtask

   // Sticky parity flag, cleared by reading it
   task automatic t_diag();
      @(negedge clock);
      parity_err <= 1'b1;
      @(negedge clock);
      parity_err <= 1'b0;
      rdchk(ETS_ADDR_DIAG, 16'h0001);
      rdchk(ETS_ADDR_DIAG, 16'h0000);
   endtask

   // Key is volatile across a reset in mid-run
   task automatic t_reset();
      acc(1'b1, ETS_ADDR_UNLOCK, ETS_UNLOCK_VALUE);
      @(negedge clock);
      rst <= 1'b1;
      repeat (2) @(negedge clock);
      rst <= 1'b0;
      rdchk(ETS_ADDR_UNLOCK, ETS_ZERO16);
   endtask

   // 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == TIMEOUT) begin
         num_errors++;
         conclude();
      end
   end

   // Reset, then each scenario in turn
   initial begin
      rst = 1'b1;
      proc_status = 8'h40;
      status_input_n = 1'b1;
      gate_in = 1'b1;
      parity_err = 1'b0;
      num_errors = 0;
      n_checks = 0;
      repeat (6) @(negedge clock);
      rst <= 1'b0;
      t_defaults();
      t_idregs();
      t_protect();
      t_modes();
      t_lock();
      t_diag();
      t_reset();
      conclude();
   end
endmodule

bind ets_param_regs ets_param_regs_asserts ets_param_regs_asserts_inst (
   .clock(clock), .rst(rst), .frame_valid(frame_valid), .ctrl_byte(ctrl_byte),
   .out_data(out_data), .status_input_n(status_input_n), .status_byte(status_byte),
   .in_data(in_data), .reg_reply(reg_reply), .write_unlocked(write_unlocked));
`default_nettype wire
